// ### hw/gscr_pkg.sv
// Package of offsets, field positions and reset values for the status and command registers
`default_nettype none

package gscr_pkg;

  // ****************************************
  // Register indices at the data port
  // ****************************************
  localparam logic [7:0] ENGINE_VIDEO_STATUS_IDX   = 8'h16;
  localparam logic [7:0] GRAPHICS_COMMAND_ONE_IDX  = 8'h17;
  localparam logic [7:0] MISC_BUS_CONTROL_IDX      = 8'h15;
  localparam logic [7:0] GRAPHICS_COMMAND_TWO_IDX  = 8'h18;
  localparam logic [7:0] INDEX_RESET               = 8'h00;

  // ****************************************
  // Status field positions
  // ****************************************
  localparam int ST_ENGINE_SRC_BIT  = 7;
  localparam int ST_WIN1_SRC_BIT    = 6;
  localparam int ST_WIN2_SRC_BIT    = 5;
  localparam int ST_QUEUE_NE_BIT    = 4;
  localparam int ST_BUSY_BIT        = 3;
  localparam int ST_FREE_LSB        = 0;
  localparam int QUEUE_DEPTH        = 8;

  // ****************************************
  // Command field positions and reset
  // ****************************************
  localparam int CMD_BLOCK_MEM_BIT   = 7;
  localparam int CMD_BURST_BIT       = 5;
  localparam int CMD_SWAP_BIT        = 4;
  localparam int CMD_ZSEL_LSB        = 2;
  localparam int CMD_APERTURE_BIT    = 1;
  localparam int CMD_LAT_OFF_BIT     = 0;
  localparam logic [7:0] CMD_RESET   = 8'h00;
  localparam logic [7:0] CMD_WR_MASK = 8'hBF;

  localparam logic [1:0] ZSEL_ALL  = 2'h0;
  localparam logic [1:0] ZSEL_LOW  = 2'h1;
  localparam logic [1:0] ZSEL_HIGH = 2'h2;

  localparam int MISC_BURST_READ_BIT = 7;

endpackage

`default_nettype wire

// ### hw/gscr_regs.sv
// Engine/video status register and graphics command register one with their control effects
`default_nettype none

// Contract
// - Status bit 7 reads 0 while the frame uses the engine source start address, else 1.
// - Status bits 6 and 5 read 0 while the frame uses window one or two source address, else 1.
// - Status bit 4 reads 0 when the engine queue is empty and 1 when it holds any entry.
// - Status bit 3 reads 1 while the drawing engine is busy and 0 when idle.
// - Status bits 2:0 give free 32-bit queue entries minus one for one to seven free entries.
// - Free code 111 means empty when bit 4 is 0 and full when bit 4 is 1.
// - With the block bit set, host memory accesses are held off while the engine is busy.
// - Command bit 5 enables burst reads and writes.
// - Command bit 4 selects byte reversal at 0 and halfword exchange at 1.
// - Command bits 3:2 select all 32, low 16 or high 16 depth-buffer bits for 00, 01, 10.
// - Depth-buffer select code 11 behaves as the normal all-32-bit setting.
// - Command bit 1 at 0 refuses mapped register access; at 1 it selects the mapped aperture.
// - Command bit 0 at 1 stops the latency timer counting.
// - The command register resets to 00h.
// - The separate burst-read enable only acts while command bit 5 is set.
module gscr_regs (
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_index_wr,
  input  wire logic [7:0]  i_index_wdata,
  input  wire logic        i_data_wr,
  input  wire logic        i_data_rd,
  input  wire logic [7:0]  i_data_wdata,
  input  wire logic        i_engine_src_used,
  input  wire logic        i_win1_src_used,
  input  wire logic        i_win2_src_used,
  input  wire logic        i_engine_busy,
  input  wire logic [3:0]  i_queue_used,
  input  wire logic        i_burst_read_allow,
  input  wire logic        i_linear_memory_enable,
  input  wire logic        i_mem_req,
  input  wire logic        i_mmio_req,
  input  wire logic [31:0] i_swap_data,
  input  wire logic [31:0] i_depth_data,
  output logic [7:0]       o_data_rdata,
  output logic             o_data_rvalid,
  output logic             o_mem_hold,
  output logic             o_mmio_refuse,
  output logic             o_burst_write_en,
  output logic             o_burst_read_en,
  output logic             o_latency_count_en,
  output logic [31:0]      o_swap_data,
  output logic [31:0]      o_depth_data
);

  // ****************************************
  // Local constants
  // ****************************************
  localparam logic [3:0] DEPTH       = 4'(gscr_pkg::QUEUE_DEPTH);
  localparam logic       BURST_RESET = gscr_pkg::CMD_RESET[gscr_pkg::CMD_BURST_BIT];
  localparam logic       LAT_RESET   = !gscr_pkg::CMD_RESET[gscr_pkg::CMD_LAT_OFF_BIT];

  // ****************************************
  // Decoding functions
  // ****************************************
  // Index compare, shared by the write and read paths
  function automatic logic idx_match(input logic [7:0] idx, input logic [7:0] target);
    idx_match = (idx == target);
  endfunction

  // Occupied count to free code; empty and full both code 111
  function automatic logic [2:0] free_code_of(input logic [3:0] used);
    logic [3:0] free_cnt;
    free_cnt = DEPTH - used;
    if ((free_cnt == 4'h0) || (free_cnt >= DEPTH)) begin
      free_code_of = 3'h7;
    end else begin
      free_code_of = 3'(free_cnt - 4'h1);
    end
  endfunction

  // High word is moved down into bits 15:0
  function automatic logic [31:0] depth_pick(input logic [1:0] sel, input logic [31:0] word);
    if (sel == gscr_pkg::ZSEL_LOW) begin
      depth_pick = {16'h0000, word[15:0]};
    end else if (sel == gscr_pkg::ZSEL_HIGH) begin
      depth_pick = {16'h0000, word[31:16]};
    end else begin
      depth_pick = word;
    end
  endfunction

  // ****************************************
  // Index register
  // ****************************************
  logic [7:0] index_q;
  logic [7:0] index_d;

  // An index write and a data access in one cycle use the old index
  assign index_d = i_index_wr ? i_index_wdata : index_q;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      index_q <= gscr_pkg::INDEX_RESET;
    end else begin
      index_q <= index_d;
    end
  end

  // ****************************************
  // Register selection
  // ****************************************
  wire hit_cmd    = idx_match(index_q, gscr_pkg::GRAPHICS_COMMAND_ONE_IDX);
  wire hit_status = idx_match(index_q, gscr_pkg::ENGINE_VIDEO_STATUS_IDX);
  wire cmd_wr     = i_data_wr && hit_cmd;

  // ****************************************
  // Command register
  // ****************************************
  logic [7:0] cmd_q;
  logic [7:0] cmd_d;

  // Bit 6 is reserved and reads 0; the status index is never written
  assign cmd_d = cmd_wr ? (i_data_wdata & gscr_pkg::CMD_WR_MASK) : cmd_q;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cmd_q <= gscr_pkg::CMD_RESET;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  // ****************************************
  // Command fields
  // ****************************************
  wire       block_mem;
  wire       burst_en;
  wire       swap_word;
  wire [1:0] zsel;
  wire       aperture;
  wire       lat_off;

  assign block_mem = cmd_q[gscr_pkg::CMD_BLOCK_MEM_BIT];
  assign burst_en  = cmd_q[gscr_pkg::CMD_BURST_BIT];
  assign swap_word = cmd_q[gscr_pkg::CMD_SWAP_BIT];
  assign zsel      = cmd_q[gscr_pkg::CMD_ZSEL_LSB +: 2];
  assign aperture  = cmd_q[gscr_pkg::CMD_APERTURE_BIT];
  assign lat_off   = cmd_q[gscr_pkg::CMD_LAT_OFF_BIT];

  // ****************************************
  // Status fields
  // ****************************************
  wire       st_engine_src;
  wire       st_win1_src;
  wire       st_win2_src;
  wire       st_queue_ne;
  wire       st_busy;
  wire [2:0] st_free;
  wire [7:0] status;

  // Source flags read 0 while that start address is in use
  assign st_engine_src = ~i_engine_src_used;
  assign st_win1_src   = ~i_win1_src_used;
  assign st_win2_src   = ~i_win2_src_used;
  assign st_queue_ne   = (i_queue_used != 4'h0);
  assign st_busy       = i_engine_busy;
  assign st_free       = free_code_of(i_queue_used);

  assign status[gscr_pkg::ST_ENGINE_SRC_BIT] = st_engine_src;
  assign status[gscr_pkg::ST_WIN1_SRC_BIT]   = st_win1_src;
  assign status[gscr_pkg::ST_WIN2_SRC_BIT]   = st_win2_src;
  assign status[gscr_pkg::ST_QUEUE_NE_BIT]   = st_queue_ne;
  assign status[gscr_pkg::ST_BUSY_BIT]       = st_busy;
  assign status[gscr_pkg::ST_FREE_LSB +: 3]  = st_free;

  // ****************************************
  // Read selection
  // ****************************************
  wire [7:0] rd_mux;
  wire [7:0] rdata_d;

  // Unmapped indices read as zero
  assign rd_mux  = hit_status ? status : (hit_cmd ? cmd_q : 8'h00);
  // Read data holds until the next read
  assign rdata_d = i_data_rd ? rd_mux : o_data_rdata;

  // ****************************************
  // Control effects
  // ****************************************
  wire hold_d;
  wire mmio_ok;
  wire refuse_d;
  wire burst_write_d;
  wire burst_read_d;
  wire lat_en_d;

  assign hold_d        = i_mem_req && block_mem && i_engine_busy;
  // Mapped registers need the aperture bit and linear mode together
  assign mmio_ok       = aperture && i_linear_memory_enable;
  assign refuse_d      = i_mmio_req && !mmio_ok;
  assign burst_write_d = burst_en;
  assign burst_read_d  = burst_en && i_burst_read_allow;
  assign lat_en_d      = !lat_off;

  // ****************************************
  // Data transforms
  // ****************************************
  wire [31:0] byte_rev;
  wire [31:0] half_swap;
  wire [31:0] swapped;
  wire [31:0] depth_sel;

  // Byte order reversed across the word
  for (genvar b = 0; b < 4; b = b + 1) begin : g_byte_rev
    assign byte_rev[8*b +: 8] = i_swap_data[8*(3-b) +: 8];
  end

  // Upper and lower halves exchanged
  for (genvar h = 0; h < 2; h = h + 1) begin : g_half_swap
    assign half_swap[16*h +: 16] = i_swap_data[16*(1-h) +: 16];
  end

  assign swapped   = swap_word ? half_swap : byte_rev;
  assign depth_sel = depth_pick(zsel, i_depth_data);

  // ****************************************
  // Read answer
  // ****************************************
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_data_rdata <= 8'h00;
    end else begin
      o_data_rdata <= rdata_d;
    end
  end

  // Valid is a one-cycle pulse after each read
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_data_rvalid <= 1'h0;
    end else begin
      o_data_rvalid <= i_data_rd;
    end
  end

  // ****************************************
  // Control outputs
  // ****************************************
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_mem_hold <= 1'h0;
    end else begin
      o_mem_hold <= hold_d;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_mmio_refuse <= 1'h0;
    end else begin
      o_mmio_refuse <= refuse_d;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_burst_write_en <= BURST_RESET;
    end else begin
      o_burst_write_en <= burst_write_d;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_burst_read_en <= 1'h0;
    end else begin
      o_burst_read_en <= burst_read_d;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_latency_count_en <= LAT_RESET;
    end else begin
      o_latency_count_en <= lat_en_d;
    end
  end

  // ****************************************
  // Data outputs
  // ****************************************
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_swap_data <= 32'h00000000;
    end else begin
      o_swap_data <= swapped;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_depth_data <= 32'h00000000;
    end else begin
      o_depth_data <= depth_sel;
    end
  end

endmodule

`default_nettype wire

// ### verification/gscr_regs_chk.sv
// Assertions on the read strobe and control outputs
`default_nettype none
module gscr_regs_chk (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_data_wr,
  input wire logic i_data_rd,
  input wire logic i_mem_req,
  input wire logic i_engine_busy,
  input wire logic i_mmio_req,
  input wire logic i_linear_memory_enable,
  input wire logic i_burst_read_allow,
  input wire logic o_data_rvalid,
  input wire logic o_mem_hold,
  input wire logic o_mmio_refuse,
  input wire logic o_burst_write_en,
  input wire logic o_burst_read_en,
  input wire logic o_latency_count_en
);
  // ****************************************
  // Output relations
  // ****************************************
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  a_hold_cause: assert property (o_mem_hold |-> $past(i_mem_req && i_engine_busy))
    else $error("hold without busy request");
  a_burst_read_gate: assert property (o_burst_read_en |-> o_burst_write_en
    && $past(i_burst_read_allow)) else $error("burst read not gated");
  // A command write reaches the control outputs two edges later
  sequence s_recent_write;
    $past(i_data_wr) || $past(i_data_wr, 2);
  endsequence
  a_burst_by_write: assert property ($changed(o_burst_write_en) |-> s_recent_write)
    else $error("burst enable moved alone");
  a_latency_by_write: assert property ($changed(o_latency_count_en) |-> s_recent_write)
    else $error("latency enable moved alone");
  a_mmio_no_linear: assert property ($past(i_mmio_req && !i_linear_memory_enable)
    |-> o_mmio_refuse) else $error("mapped access not refused");
  a_mmio_cause: assert property (o_mmio_refuse |-> $past(i_mmio_req))
    else $error("refuse without request");
  a_read_answer: assert property (i_data_rd |=> o_data_rvalid)
    else $error("read not answered");
  a_read_pulse: assert property (!i_data_rd |=> !o_data_rvalid)
    else $error("stray read valid");
endmodule
bind gscr_regs gscr_regs_chk u_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_data_wr(i_data_wr), .i_data_rd(i_data_rd),
  .i_mem_req(i_mem_req), .i_engine_busy(i_engine_busy), .i_mmio_req(i_mmio_req),
  .i_linear_memory_enable(i_linear_memory_enable), .i_burst_read_allow(i_burst_read_allow),
  .o_data_rvalid(o_data_rvalid), .o_mem_hold(o_mem_hold), .o_mmio_refuse(o_mmio_refuse),
  .o_burst_write_en(o_burst_write_en), .o_burst_read_en(o_burst_read_en),
  .o_latency_count_en(o_latency_count_en)
);
`default_nettype wire

// ### verification/graphics_status_command_regs_tb_top.sv
// Self-checking bench for the status and command registers
`default_nettype none
module graphics_status_command_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk = '0, i_rst = 1'h1, i_index_wr = '0, i_data_wr = '0, i_data_rd = '0;
  logic i_engine_src_used, i_win1_src_used, i_win2_src_used, i_engine_busy, i_mem_req;
  logic i_burst_read_allow, i_linear_memory_enable, i_mmio_req, o_data_rvalid, o_mem_hold;
  logic o_mmio_refuse, o_burst_write_en, o_burst_read_en, o_latency_count_en;
  logic [7:0] i_index_wdata = '0, i_data_wdata = '0, o_data_rdata, c;
  logic [3:0] i_queue_used = '0;
  logic [31:0] i_swap_data = '0, i_depth_data = '0, o_swap_data, o_depth_data, r = 32'h12753, d;
  int failures = 0, compares = 0;
  gscr_regs dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_index_wr(i_index_wr), .i_index_wdata(i_index_wdata),
    .i_data_wr(i_data_wr), .i_data_rd(i_data_rd), .i_data_wdata(i_data_wdata),
    .i_engine_src_used(i_engine_src_used), .i_win1_src_used(i_win1_src_used),
    .i_win2_src_used(i_win2_src_used), .i_engine_busy(i_engine_busy),
    .i_queue_used(i_queue_used), .i_burst_read_allow(i_burst_read_allow),
    .i_linear_memory_enable(i_linear_memory_enable), .i_mem_req(i_mem_req),
    .i_mmio_req(i_mmio_req), .i_swap_data(i_swap_data), .i_depth_data(i_depth_data),
    .o_data_rdata(o_data_rdata), .o_data_rvalid(o_data_rvalid), .o_mem_hold(o_mem_hold),
    .o_mmio_refuse(o_mmio_refuse), .o_burst_write_en(o_burst_write_en),
    .o_burst_read_en(o_burst_read_en), .o_latency_count_en(o_latency_count_en),
    .o_swap_data(o_swap_data), .o_depth_data(o_depth_data)
  );
  always #10 i_mclk = ~i_mclk;
  // ****************************************
  // Model, compare and bus tasks
  // ****************************************
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] st();
    int f = gscr_pkg::QUEUE_DEPTH - i_queue_used;
    return {!i_engine_src_used, !i_win1_src_used, !i_win2_src_used, i_queue_used != 0,
      i_engine_busy, (f > 0 && f < gscr_pkg::QUEUE_DEPTH) ? 3'(f - 1) : 3'h7};
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic acc(logic [7:0] x, logic [7:0] v, logic w);
    @(negedge i_mclk);
    i_index_wr = 1'h1;
    i_index_wdata = x;
    @(negedge i_mclk);
    i_index_wr = '0;
    i_data_wr = w;
    i_data_rd = !w;
    i_data_wdata = v;
    @(negedge i_mclk);
    {i_data_wr, i_data_rd} = '0;
    if (!w) begin
      chk("read valid", 1'h1, o_data_rvalid);
    end
  endtask
  initial begin
    {i_engine_src_used, i_win1_src_used, i_win2_src_used, i_engine_busy} = '0;
    {i_burst_read_allow, i_linear_memory_enable, i_mem_req, i_mmio_req} = '0;
    repeat (16) @(negedge i_mclk);
    i_rst = '0;
    acc(8'h17, '0, '0);
    chk("command", 8'h00, o_data_rdata);
    chk("latency", 1'h1, o_latency_count_en);
    $display("reset test done");
    for (int k = 0; k < 72; k++) begin
      r = nx(r);
      {i_engine_src_used, i_win1_src_used, i_win2_src_used, i_engine_busy, i_burst_read_allow,
        i_linear_memory_enable, i_mem_req, i_mmio_req} = r[31:24];
      i_queue_used = 4'(k % 9);
      i_swap_data = nx(r);
      i_depth_data = ~r;
      c = r[7:0];
      d = i_depth_data;
      i_linear_memory_enable = '0;
      acc(8'h17, c, 1'h1);
      i_linear_memory_enable = r[26] & c[1];
      acc(8'h16, ~c, 1'h1);
      acc(8'h17, '0, '0);
      chk("command", c & 8'hBF, o_data_rdata);
      acc(8'h16, '0, '0);
      chk("status", st(), o_data_rdata);
      chk("hold", c[7] & i_mem_req & i_engine_busy, o_mem_hold);
      chk("burst", c[5], o_burst_write_en);
      chk("burst read", c[5] & i_burst_read_allow, o_burst_read_en);
      chk("latency", !c[0], o_latency_count_en);
      chk("refuse", i_mmio_req & !(c[1] & i_linear_memory_enable), o_mmio_refuse);
      chk("swap", c[4] ? {i_swap_data[15:0], i_swap_data[31:16]} : {i_swap_data[7:0],
        i_swap_data[15:8], i_swap_data[23:16], i_swap_data[31:24]}, o_swap_data);
      chk("depth", c[3:2] == 2'h1 ? {16'h0, d[15:0]} : c[3:2] == 2'h2 ? {16'h0, d[31:16]} : d,
        o_depth_data);
    end
    $display("random test done");
    {i_linear_memory_enable, i_mmio_req, i_mem_req} = '0;
    i_rst = 1'h1;
    repeat (2) @(negedge i_mclk);
    i_rst = '0;
    acc(8'h17, '0, '0);
    chk("command", 8'h00, o_data_rdata);
    chk("burst", 1'h0, o_burst_write_en);
    chk("latency", 1'h1, o_latency_count_en);
    $display("mid-run reset test done");
    conclude();
  end
endmodule
`default_nettype wire
